// file: hdl/ces_exception_sequencer.sv
// Exception entry sequencer: status change, vector acquisition, stacking, vector fetch
`timescale 1ns/1ps
`default_nettype none
module ces_exception_sequencer
  import ces_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic resetReq,
  input wire logic busErrorReq,
  input wire logic addressErrorReq,
  input wire logic instrBoundary,
  input wire logic nextIllegal,
  input wire logic nextPrivilege,
  input wire logic nextLineA,
  input wire logic nextLineF,
  input wire logic trapReq,
  input wire logic [3:0] trapNumber,
  input wire logic overflowTrapReq,
  input wire logic boundsCheckReq,
  input wire logic zeroDivideReq,
  input wire logic [2:0] irqLevel,
  input wire logic [23:0] pcIn,
  input wire logic [23:0] faultAddress,
  input wire logic [15:0] faultOpcode,
  input wire logic [15:0] faultInfo,
  input wire logic srWriteEn,
  input wire logic [15:0] srWriteData,
  input wire logic sspWriteEn,
  input wire logic [23:0] sspWriteData,
  output logic [15:0] statusWord,
  output logic [23:0] supervisor_stack_pointer,
  output logic [23:0] newPc,
  output logic pcLoad,
  output logic excActive,
  output logic abortInstr,
  output logic halted,
  output logic [7:0] vectorNumber,
  output logic busReq,
  output logic busWrite,
  output logic [23:0] busAddr,
  output logic [2:0] busFc,
  output logic [15:0] busWdata,
  input wire logic busAck,
  input wire logic busErr,
  input wire logic busAutovector,
  input wire logic [15:0] busRdata
);

  ces_state_t state;
  ces_cause_t cause;
  logic [15:0] srCopy;
  logic [23:0] retPc;
  logic [23:0] savedFaultAddr;
  logic [15:0] savedFaultOpcode;
  logic [15:0] savedFaultInfo;
  logic [2:0] takenLevel;
  logic [2:0] pushIdx;
  logic wordIdx;
  logic busGap;
  logic [2:0] prevLevel;
  logic nmiPend;
  logic [23:0] resetSsp;

  logic selValid;
  ces_cause_t selCause;
  logic [7:0] selVector;
  logic irqTake;
  logic xferDone;
  logic [2:0] pushCount;
  logic [23:0] vecAddr;
  logic abortNow;

  // Level above mask, or a fresh entry into level seven
  assign irqTake = (irqLevel > statusWord[SR_MASK_LSB +: 3]) || nmiPend;
  assign xferDone = busReq && busAck;
  assign pushCount = (cause == CAUSE_BUS_ERR || cause == CAUSE_ADDR_ERR) ? PUSH_WORDS_LONG : PUSH_WORDS_SHORT;
  assign vecAddr = {14'h0000, vectorNumber, 2'b00} & VEC_TABLE_LAST;
  assign abortNow = resetReq || busErrorReq || addressErrorReq;

  ces_cause_select u_select (
    .resetReq(resetReq),
    .busErrorReq(busErrorReq),
    .addressErrorReq(addressErrorReq),
    .boundary(instrBoundary),
    .traceOn(statusWord[SR_TRACE_BIT]),
    .irqTake(irqTake),
    .nextIllegal(nextIllegal),
    .nextPrivilege(nextPrivilege),
    .nextLineA(nextLineA),
    .nextLineF(nextLineF),
    .trapReq(trapReq),
    .trapNumber(trapNumber),
    .overflowTrapReq(overflowTrapReq),
    .boundsCheckReq(boundsCheckReq),
    .zeroDivideReq(zeroDivideReq),
    .selValid(selValid),
    .selCause(selCause),
    .selVector(selVector)
  );
  // Bus request is held until answered, then dropped for one cycle
  always_comb
  begin
    busReq = 1'b0;
    busWrite = 1'b0;
    busAddr = 24'h000000;
    busFc = FC_SUP_DATA;
    busWdata = 16'h0000;
    case (state)
      ST_IACK:
      begin
        busReq = !busGap;
        busAddr = {IACK_ADDR_HIGH, takenLevel, 1'b1};
        busFc = FC_IACK;
      end
      ST_PUSH:
      begin
        busReq = !busGap;
        busWrite = 1'b1;
        busAddr = supervisor_stack_pointer - STACK_STEP;
        case (pushIdx)
          3'h0: busWdata = retPc[15:0];
          3'h1: busWdata = {8'h00, retPc[23:16]};
          3'h2: busWdata = srCopy;
          3'h3: busWdata = savedFaultOpcode;
          3'h4: busWdata = savedFaultAddr[15:0];
          3'h5: busWdata = {8'h00, savedFaultAddr[23:16]};
          default: busWdata = savedFaultInfo;
        endcase
      end
      ST_RSSP:
      begin
        busReq = !busGap;
        busAddr = RESET_ENTRY_ADDR + {22'h000000, wordIdx, 1'b0};
        busFc = FC_SUP_PROG;
      end
      ST_VEC:
      begin
        busReq = !busGap;
        busAddr = (cause == CAUSE_RESET) ? (vecAddr + {21'h000000, 1'b1, wordIdx, 1'b0})
                                         : (vecAddr + {22'h000000, wordIdx, 1'b0});
        busFc = (cause == CAUSE_RESET) ? FC_SUP_PROG : FC_SUP_DATA;
      end
      default: busReq = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      busGap <= 1'b0;
    else
      busGap <= busReq && (busAck || busErr);
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= ST_STEP1;
      cause <= CAUSE_RESET;
      vectorNumber <= VEC_RESET;
      pushIdx <= 3'h0;
      wordIdx <= 1'b0;
      retPc <= 24'h000000;
      takenLevel <= LEVEL_NMI;
      savedFaultAddr <= 24'h000000;
      savedFaultOpcode <= 16'h0000;
      savedFaultInfo <= 16'h0000;
    end
    else if (resetReq && !(state == ST_STEP1 && cause == CAUSE_RESET))
    begin
      state <= ST_STEP1;
      cause <= CAUSE_RESET;
      vectorNumber <= VEC_RESET;
      takenLevel <= LEVEL_NMI;
    end
    else if ((busErrorReq || addressErrorReq) && state != ST_IDLE && state != ST_HALT)
    begin
      state <= ST_HALT; // Fault during entry: double fault
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (selValid)
          begin
            state <= ST_STEP1;
            cause <= selCause;
            vectorNumber <= selVector;
            retPc <= pcIn;
            takenLevel <= irqLevel;
            savedFaultAddr <= faultAddress;
            savedFaultOpcode <= faultOpcode;
            savedFaultInfo <= faultInfo;
          end
        end
        ST_STEP1:
        begin
          pushIdx <= 3'h0;
          wordIdx <= 1'b0;
          if (cause == CAUSE_IRQ)
            state <= ST_IACK;
          else if (cause == CAUSE_RESET)
            state <= ST_RSSP;
          else
            state <= ST_PUSH;
        end
        ST_IACK:
        begin
          if (busReq && (busAck || busErr))
          begin
            state <= ST_PUSH;
            if (busErr)
              vectorNumber <= VEC_SPURIOUS;
            else if (busAutovector)
              vectorNumber <= VEC_AUTO_BASE + {5'h00, takenLevel};
            else
              vectorNumber <= busRdata[7:0];
          end
        end
        ST_PUSH:
        begin
          if (busReq && busErr)
            state <= ST_HALT;
          else if (xferDone)
          begin
            pushIdx <= pushIdx + 3'h1;
            if (pushIdx + 3'h1 == pushCount)
              state <= ST_VEC;
          end
        end
        ST_RSSP, ST_VEC:
        begin
          if (busReq && busErr)
            state <= ST_HALT;
          else if (xferDone)
          begin
            wordIdx <= !wordIdx;
            if (wordIdx)
              state <= (state == ST_RSSP) ? ST_VEC : ST_FINISH;
          end
        end
        ST_FINISH:
        begin
          if (cause != CAUSE_IRQ && irqTake && !abortNow)
          begin
            state <= ST_STEP1;
            cause <= CAUSE_IRQ;
            vectorNumber <= VEC_SPURIOUS;
            retPc <= newPc;
            takenLevel <= irqLevel;
          end
          else
            state <= ST_IDLE;
        end
        default: state <= ST_HALT;
      endcase
    end
  end
  // Status word: snapshot then supervisor, trace off, mask update for reset and interrupt only
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      statusWord <= SR_RESET;
      srCopy <= 16'h0000;
    end
    else if (state == ST_STEP1)
    begin
      srCopy <= statusWord;
      statusWord[SR_SUPER_BIT] <= 1'b1;
      statusWord[SR_TRACE_BIT] <= 1'b0;
      if (cause == CAUSE_RESET || cause == CAUSE_IRQ)
        statusWord[SR_MASK_LSB +: 3] <= takenLevel;
    end
    else if (state == ST_IDLE && srWriteEn && !selValid)
      statusWord <= srWriteData;
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      supervisor_stack_pointer <= 24'h000000;
      resetSsp <= 24'h000000;
    end
    else if (state == ST_PUSH && xferDone)
      supervisor_stack_pointer <= supervisor_stack_pointer - STACK_STEP;
    else if (state == ST_RSSP && xferDone)
    begin
      if (wordIdx)
        supervisor_stack_pointer <= {resetSsp[23:16], busRdata};
      else
        resetSsp <= {busRdata[7:0], 16'h0000};
    end
    else if (state == ST_IDLE && sspWriteEn && !selValid)
      supervisor_stack_pointer <= sspWriteData;
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      newPc <= 24'h000000;
    else if (state == ST_VEC && xferDone)
    begin
      if (wordIdx)
        newPc[15:0] <= busRdata;
      else
        newPc[23:16] <= busRdata[7:0];
    end
  end
  // Level seven edge detection; a new edge wins over the clear
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prevLevel <= 3'h0;
      nmiPend <= 1'b0;
    end
    else
    begin
      prevLevel <= irqLevel;
      if (irqLevel == LEVEL_NMI && prevLevel != LEVEL_NMI)
        nmiPend <= 1'b1;
      else if (state == ST_STEP1 && cause == CAUSE_IRQ && takenLevel == LEVEL_NMI)
        nmiPend <= 1'b0;
    end
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pcLoad <= 1'b0;
      excActive <= 1'b1;
      abortInstr <= 1'b0;
      halted <= 1'b0;
    end
    else
    begin
      pcLoad <= (state == ST_FINISH) && !abortNow && !(cause != CAUSE_IRQ && irqTake);
      excActive <= (state != ST_IDLE && state != ST_HALT) || (state == ST_IDLE && selValid);
      abortInstr <= abortNow && state == ST_IDLE;
      halted <= (state == ST_HALT) && !resetReq;
    end
  end

endmodule : ces_exception_sequencer
`default_nettype wire

// file: hdl/ces_pkg.sv
// Constants and types shared by the exception sequencer files
package ces_pkg;

  localparam logic [7:0] VEC_RESET = 8'h00;
  localparam logic [7:0] VEC_BUS_ERROR = 8'h02;
  localparam logic [7:0] VEC_ADDR_ERROR = 8'h03;
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] VEC_ZERO_DIVIDE = 8'h05;
  localparam logic [7:0] VEC_BOUNDS_CHECK = 8'h06;
  localparam logic [7:0] VEC_OVERFLOW_TRAP = 8'h07;
  localparam logic [7:0] VEC_PRIVILEGE = 8'h08;
  localparam logic [7:0] VEC_TRACE = 8'h09;
  localparam logic [7:0] VEC_LINE_A = 8'h0A;
  localparam logic [7:0] VEC_LINE_F = 8'h0B;
  localparam logic [7:0] VEC_UNINIT = 8'h0F;
  localparam logic [7:0] VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h20;

  localparam logic [23:0] VEC_TABLE_LAST = 24'h0003FF;
  localparam logic [23:0] RESET_ENTRY_ADDR = 24'h000000;
  localparam logic [19:0] IACK_ADDR_HIGH = 20'hFFFFF;

  localparam logic [2:0] FC_SUP_DATA = 3'b101;
  localparam logic [2:0] FC_SUP_PROG = 3'b110;
  localparam logic [2:0] FC_IACK = 3'b111;

  localparam int SR_TRACE_BIT = 15;
  localparam int SR_SUPER_BIT = 13;
  localparam int SR_MASK_LSB = 8;
  localparam logic [15:0] SR_RESET = 16'h2700;
  localparam logic [2:0] LEVEL_NMI = 3'h7;

  localparam logic [2:0] PUSH_WORDS_SHORT = 3'h3;
  localparam logic [2:0] PUSH_WORDS_LONG = 3'h7;
  localparam logic [23:0] STACK_STEP = 24'h000002;

  typedef enum logic [3:0] {
    CAUSE_RESET = 4'h0,
    CAUSE_BUS_ERR = 4'h1,
    CAUSE_ADDR_ERR = 4'h2,
    CAUSE_TRACE = 4'h3,
    CAUSE_IRQ = 4'h4,
    CAUSE_ILLEGAL = 4'h5,
    CAUSE_PRIV = 4'h6,
    CAUSE_LINE_A = 4'h7,
    CAUSE_LINE_F = 4'h8,
    CAUSE_TRAP = 4'h9,
    CAUSE_OVF = 4'hA,
    CAUSE_CHK = 4'hB,
    CAUSE_ZDIV = 4'hC
  } ces_cause_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_STEP1 = 8'h02,
    ST_IACK = 8'h04,
    ST_PUSH = 8'h08,
    ST_RSSP = 8'h10,
    ST_VEC = 8'h20,
    ST_FINISH = 8'h40,
    ST_HALT = 8'h80
  } ces_state_t;

endpackage : ces_pkg

// file: hdl/ces_cause_select.sv
// Priority resolution of pending exception causes and their vector numbers
`timescale 1ns/1ps
`default_nettype none
module ces_cause_select
  import ces_pkg::*;
(
  input wire logic resetReq,
  input wire logic busErrorReq,
  input wire logic addressErrorReq,
  input wire logic boundary,
  input wire logic traceOn,
  input wire logic irqTake,
  input wire logic nextIllegal,
  input wire logic nextPrivilege,
  input wire logic nextLineA,
  input wire logic nextLineF,
  input wire logic trapReq,
  input wire logic [3:0] trapNumber,
  input wire logic overflowTrapReq,
  input wire logic boundsCheckReq,
  input wire logic zeroDivideReq,
  output logic selValid,
  output ces_cause_t selCause,
  output logic [7:0] selVector
);

  always_comb
  begin
    selValid = 1'b1;
    selCause = CAUSE_RESET;
    selVector = VEC_RESET;
    if (resetReq)
    begin
      selCause = CAUSE_RESET;
      selVector = VEC_RESET;
    end
    else if (busErrorReq)
    begin
      selCause = CAUSE_BUS_ERR;
      selVector = VEC_BUS_ERROR;
    end
    else if (addressErrorReq)
    begin
      selCause = CAUSE_ADDR_ERR;
      selVector = VEC_ADDR_ERROR;
    end
    else if (boundary && traceOn)
    begin
      selCause = CAUSE_TRACE;
      selVector = VEC_TRACE;
    end
    else if (boundary && irqTake)
    begin
      selCause = CAUSE_IRQ;
      selVector = VEC_SPURIOUS;
    end
    else if (boundary && nextIllegal)
    begin
      selCause = CAUSE_ILLEGAL;
      selVector = VEC_ILLEGAL;
    end
    else if (boundary && nextLineA)
    begin
      selCause = CAUSE_LINE_A;
      selVector = VEC_LINE_A;
    end
    else if (boundary && nextLineF)
    begin
      selCause = CAUSE_LINE_F;
      selVector = VEC_LINE_F;
    end
    else if (boundary && nextPrivilege)
    begin
      selCause = CAUSE_PRIV;
      selVector = VEC_PRIVILEGE;
    end
    else if (trapReq)
    begin
      selCause = CAUSE_TRAP;
      selVector = VEC_TRAP_BASE + {4'h0, trapNumber};
    end
    else if (overflowTrapReq)
    begin
      selCause = CAUSE_OVF;
      selVector = VEC_OVERFLOW_TRAP;
    end
    else if (boundsCheckReq)
    begin
      selCause = CAUSE_CHK;
      selVector = VEC_BOUNDS_CHECK;
    end
    else if (zeroDivideReq)
    begin
      selCause = CAUSE_ZDIV;
      selVector = VEC_ZERO_DIVIDE;
    end
    else
    begin
      selValid = 1'b0;
    end
  end

endmodule : ces_cause_select
`default_nettype wire

// file: test/ces_seq_assertions.sv
// Port-level checker for the exception sequencer, bound into the design
`timescale 1ns/1ps
`default_nettype none
module ces_seq_assertions
  import ces_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic resetReq,
  input wire logic busErrorReq,
  input wire logic addressErrorReq,
  input wire logic [15:0] statusWord,
  input wire logic pcLoad,
  input wire logic excActive,
  input wire logic abortInstr,
  input wire logic halted,
  input wire logic [7:0] vectorNumber,
  input wire logic busReq,
  input wire logic busWrite,
  input wire logic [23:0] busAddr,
  input wire logic [2:0] busFc,
  input wire logic busAck,
  input wire logic busErr,
  input wire logic busAutovector
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // Vector table read, acknowledge cycles excluded
  wire logic rd = busReq && !busWrite && busFc != FC_IACK;

  a_super_only: assert property (busReq |-> busFc[2])
    else $error("bus request outside supervisor space");
  a_vec_space: assert property (rd |-> busFc == (busAddr < 24'h8 ? FC_SUP_PROG : FC_SUP_DATA))
    else $error("vector read with wrong space code");
  a_table_bound: assert property (rd |-> busAddr <= VEC_TABLE_LAST)
    else $error("vector read outside the table");
  a_vec_index: assert property (rd && busFc == FC_SUP_DATA |-> busAddr[9:2] == vectorNumber)
    else $error("vector address not four times vector number");
  a_vec_pair: assert property (rd && busAck && !busAddr[1] && !resetReq |=>
    !busReq ##1 busReq && busAddr == $past(busAddr, 2) + 24'h2)
    else $error("second word of vector entry not fetched next");
  a_push_order: assert property (busReq && busWrite && busAck && !resetReq |=>
    !busReq ##1 (busWrite -> busAddr == $past(busAddr, 2) - 24'h2))
    else $error("stack pushes not at descending words");
  a_iack_form: assert property (busReq && busFc == FC_IACK |->
    !busWrite && busAddr[23:4] == IACK_ADDR_HIGH && busAddr[0] && busAddr[3:1] == statusWord[10:8])
    else $error("acknowledge cycle malformed");
  a_entry_status: assert property ($rose(excActive) |=> statusWord[13] && !statusWord[15])
    else $error("entry did not set supervisor and clear trace");
  a_abort_start: assert property (!excActive && !halted && !pcLoad
    && (resetReq || busErrorReq || addressErrorReq) |=> abortInstr && excActive)
    else $error("abort request not started at once");
  a_pc_source: assert property (pcLoad |-> $past(busAck) || $past(busAck, 2) || $past(busAck, 3))
    else $error("program counter load without vector read");
  a_halt_stays: assert property (halted && !resetReq |=> halted)
    else $error("halt left without reset");
  a_req_hold: assert property (busReq && !busAck && !busErr && !resetReq |=>
    busReq && $stable(busAddr) && $stable(busFc) && $stable(busWrite))
    else $error("bus request changed before answer");

  c_iack_auto: cover property (busReq && busFc == FC_IACK && busAutovector);
  c_halt: cover property ($rose(halted));
  c_push: cover property (busReq && busWrite && busAck);
endmodule : ces_seq_assertions

bind ces_exception_sequencer ces_seq_assertions u_chk (.core_clk, .nrst, .resetReq, .busErrorReq,
  .addressErrorReq, .statusWord, .pcLoad, .excActive, .abortInstr, .halted, .vectorNumber, .busReq,
  .busWrite, .busAddr, .busFc, .busAck, .busErr, .busAutovector);
`default_nettype wire

// file: test/ces_bus_partner.sv
// Bus-side model: vector memory, stack memory and an interrupting peripheral
`timescale 1ns/1ps
`default_nettype none
module ces_bus_partner
  import ces_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic busReq,
  input wire logic [23:0] busAddr,
  input wire logic [2:0] busFc,
  input wire logic [1:0] lat,
  input wire logic [7:0] ivec,
  input wire logic auto,
  input wire logic errOn,
  output logic busAck,
  output logic busErr,
  output logic busAutovector,
  output logic [15:0] busRdata
);
  logic [1:0] cnt;
  logic armed;
  logic [15:0] val;
  wire logic iack = busFc == FC_IACK;
  // Vector only on the low byte; the high byte carries junk
  assign val = iack ? {~ivec, ivec} : busAddr[15:0] + 16'h1000;
  // Bus not in use shows the inverse, never the last word
  assign busRdata = busReq ? val : ~val;
  assign busAutovector = auto && iack && busAck;
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      busAck <= 1'b0;
      busErr <= 1'b0;
      cnt <= 2'h0;
      armed <= 1'b0;
    end
    else
    begin
      busAck <= 1'b0;
      busErr <= 1'b0;
      if (errOn)
        armed <= 1'b1;
      if (busReq && !busAck && !busErr)
      begin
        cnt <= (cnt >= lat) ? 2'h0 : cnt + 2'h1;
        // One armed error answers the next transfer instead of an ack
        if (cnt >= lat && armed)
          armed <= 1'b0;
        busErr <= cnt >= lat && armed;
        busAck <= cnt >= lat && !armed;
      end
    end
endmodule : ces_bus_partner
`default_nettype wire

// file: test/tb_top.sv
// Directed tests of the exception entry sequences
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ces_pkg::*;
;
  logic core_clk, pcLoad, excActive, abortInstr, halted, busReq, busWrite, busAck, busErr, busAutovector;
  logic nrst = 0, auto = 0, errOn = 0, srWriteEn = 0, sspWriteEn = 0;
  logic [11:0] req = '0;
  logic [3:0] trapNumber = 4'hF, nwr = 4'h0;
  logic [2:0] irqLevel = 3'h0, busFc;
  logic [1:0] lat = 2'h0;
  logic [7:0] vectorNumber, ivec = 8'h00;
  logic [15:0] faultOpcode = 16'h4E71, faultInfo = 16'h0015, srWriteData = 16'h0000;
  logic [15:0] statusWord, busWdata, busRdata;
  logic [23:0] pcIn = 24'h123456, faultAddress = 24'h00ABCD, sspWriteData = 24'h000000;
  logic [23:0] supervisor_stack_pointer, newPc, busAddr;
  logic [15:0] wr [8];
  int nMismatch = 0;
  int cmpCount = 0;
  // Request, vector and pushed word count for each internal cause but trace
  logic [23:0] tbl [12] = '{24'h0802F3, 24'h100073, 24'h200063, 24'h400053, 24'h00C043, 24'h014083,
    24'h0240A3, 24'h0440B3, 24'h001027, 24'h002037, 24'h083027, 24'h01C043};

  ces_exception_sequencer dut (.core_clk, .nrst, .resetReq(req[11]), .busErrorReq(req[0]),
    .addressErrorReq(req[1]), .instrBoundary(req[2]), .nextIllegal(req[3]), .nextPrivilege(req[4]),
    .nextLineA(req[5]), .nextLineF(req[6]), .trapReq(req[7]), .trapNumber, .overflowTrapReq(req[8]),
    .boundsCheckReq(req[9]), .zeroDivideReq(req[10]), .irqLevel, .pcIn, .faultAddress, .faultOpcode,
    .faultInfo, .srWriteEn, .srWriteData, .sspWriteEn, .sspWriteData, .statusWord, .supervisor_stack_pointer,
    .newPc, .pcLoad, .excActive, .abortInstr, .halted, .vectorNumber, .busReq, .busWrite, .busAddr, .busFc,
    .busWdata, .busAck, .busErr, .busAutovector, .busRdata);
  ces_bus_partner mem (.core_clk, .nrst, .busReq, .busAddr, .busFc, .lat, .ivec, .auto, .errOn, .busAck,
    .busErr, .busAutovector, .busRdata);

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    if (busReq && busAck && busWrite)
    begin
      wr[nwr[2:0]] <= busWdata;
      nwr <= nwr + 4'h1;
    end

  task automatic testDone;
    $display("compares %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : testDone

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [23:0] epc(input logic [7:0] v);
    logic [15:0] a;
    a = {6'h00, v, 2'b00};
    return {a[7:0], a + 16'h1002};
  endfunction : epc

  task automatic pulse(input logic [11:0] r);
    @(posedge core_clk);
    req <= r;
    lat <= lat + 2'h1;
    @(posedge core_clk);
    req <= 12'h000;
  endtask : pulse

  task automatic wt(input logic h);
    for (int i = 0; i < 400 && (h ? halted : pcLoad) !== 1'b1; i++)
      @(posedge core_clk) #1;
    chk(h ? halted : pcLoad, 24'h1);
  endtask : wt

  task automatic boot;
    wt(1'b0);
    chk(newPc, 24'h041006);
    chk(supervisor_stack_pointer, 24'h001002);
    chk(statusWord, 24'h2700);
    chk(halted, 24'h0);
  endtask : boot

  task automatic exc(input logic [11:0] r, input logic [7:0] v, input logic [3:0] nw);
    logic [15:0] s0;
    logic [23:0] p0;
    s0 = statusWord;
    p0 = supervisor_stack_pointer;
    nwr = 4'h0;
    pulse(r);
    wt(1'b0);
    chk(vectorNumber, v);
    chk(newPc, epc(v));
    chk(nwr, nw);
    chk(supervisor_stack_pointer, p0 - {nw, 1'b0});
    chk(statusWord[15:13], 24'h1);
    if (nw != 4'h0)
    begin
      chk(wr[0], pcIn[15:0]);
      chk(wr[1], {8'h00, pcIn[23:16]});
      chk(wr[2], s0);
    end
    if (nw == 4'h7)
    begin
      chk(wr[3], faultOpcode);
      chk(wr[4], faultAddress[15:0]);
      chk(wr[6], faultInfo);
    end
  endtask : exc

  task automatic noexc(input logic [11:0] r);
    pulse(r);
    repeat (8) @(posedge core_clk);
    #1;
    chk(excActive, 24'h0);
  endtask : noexc

  task automatic wreg(input logic k, input logic [23:0] d);
    @(posedge core_clk);
    srWriteEn <= !k;
    sspWriteEn <= k;
    srWriteData <= d[15:0];
    sspWriteData <= d;
    @(posedge core_clk);
    srWriteEn <= 1'b0;
    sspWriteEn <= 1'b0;
    #1;
  endtask : wreg

  task automatic irq(input logic [2:0] l, input logic [7:0] v, input logic a);
    @(posedge core_clk);
    irqLevel <= l;
    ivec <= v;
    auto <= a;
  endtask : irq

  task automatic arm;
    @(posedge core_clk);
    errOn <= 1'b1;
    @(posedge core_clk);
    errOn <= 1'b0;
  endtask : arm

  initial
  begin
    #200000;
    nMismatch++;
    testDone;
  end

  initial
  begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    boot;
    wreg(1'b1, 24'h002000);
    chk(supervisor_stack_pointer, 24'h002000);
    wreg(1'b0, 24'h000000);
    for (int i = 0; i < 12; i++)
      exc(tbl[i][23:12], tbl[i][11:4], tbl[i][3:0]);
    wreg(1'b0, 24'h00A000);
    exc(12'h004, 8'h09, 4'h3);
    chk(statusWord[15], 24'h0);
    wreg(1'b0, 24'h00A000);
    exc(12'h00C, 8'h09, 4'h3);
    wreg(1'b0, 24'h002000);
    irq(3'h3, 8'h40, 1'b0);
    exc(12'h004, 8'h40, 4'h3);
    chk(statusWord[10:8], 24'h3);
    noexc(12'h004);
    irq(3'h5, 8'h40, 1'b1);
    exc(12'h004, 8'h1D, 4'h3);
    irq(3'h6, 8'h40, 1'b0);
    arm;
    exc(12'h004, 8'h18, 4'h3);
    irq(3'h0, 8'h40, 1'b1);
    wreg(1'b0, 24'h002700);
    irq(3'h7, 8'h40, 1'b1);
    exc(12'h004, 8'h1F, 4'h3);
    noexc(12'h004);
    wreg(1'b0, 24'h00A000);
    irq(3'h2, 8'h41, 1'b0);
    exc(12'h004, 8'h41, 4'h6);
    irq(3'h0, 8'h00, 1'b0);
    arm;
    pulse(12'h080);
    wt(1'b1);
    pulse(12'h800);
    boot;
    testDone;
  end
endmodule : tb_top
`default_nettype wire
